// >>> cdr_pkg.sv
/*
 Package for the comparator and reference DAC control block: offsets, field
 positions, reset values and encodings.
 Assumes APB slave with 32-bit data; registers occupy the low byte of a word.
*/
// Functional notes
// [R01] Reference DAC enable bit 7 turns the DAC on, clear turns it off.
// [R02] Pin-output enable bit 5 routes DAC level to the DAC pin.
// [R03] While pin carries the level, its digital driver and input detector are off.
// [R04] Port read of the DAC pin returns zero while assigned to reference output.
// [R05] Wake from sleep leaves the DAC control register unchanged.
// [R06] Reset disables DAC, removes pin output and clears the level code.
// [R07] Positive source select: 00 supply, 01 ext ref pin, 10 buffer 2, 11 reserved.
// [R08] DAC level register holds a full 8-bit read/write ladder tap code.
// [R09] DAC control bits 6, 4, 1, 0 ignore writes and read zero.
// [R10] Raw result low when positive input below negative, high when above.
// [R11] Two comparators, each with two control registers.
// [R12] Comparator enable bit starts it; clear puts it in lowest-current state.
// [R13] Result readable in per-comparator status bit and shared mirror register.
// [R14] Result on pin only if out-enable set, direction clear, comparator on.
// [R15] Out-enable overrides port latch regardless of comparator enable.
// [R16] Internal result latched each cycle; pin path unregistered unless sync.
// [R17] Invert bit 0 passes raw comparison, 1 inverts it.
// [R18] Speed select resets to 1 normal speed; 0 selects low power.
// [R19] Hysteresis enable bit turns input hysteresis on and off.
// [R20] Comparator result offered as gate source to the gate timer.
// [R21] Software should enable sync so gate timer never counts during changes.
// [R22] With sync set, output sampled on falling edge of prescaled timer clock.
// [R23] Irq flag set on rising edge with rise enable or falling with fall enable.
// [R24] Positive input select: 00 pin, 01 DAC, 10 buffer 2, 11 ground.
// [R25] Register writes take effect on the next clock edge.
package cdr_pkg;
	localparam logic [11:0] OFF_DAC_CTRL = 12'h000;
	localparam logic [11:0] OFF_DAC_LEVEL = 12'h004;
	localparam logic [11:0] OFF_CMP_A0 = 12'h008;
	localparam logic [11:0] OFF_CMP_B0 = 12'h00c;
	localparam logic [11:0] OFF_CMP_A1 = 12'h010;
	localparam logic [11:0] OFF_CMP_B1 = 12'h014;
	localparam logic [11:0] OFF_MIRROR = 12'h018;
	localparam logic [11:0] OFF_IRQ_FLAG = 12'h01c;
	localparam logic [11:0] OFF_PORT = 12'h020;
	localparam int DAC_ON_BIT = 7;
	localparam int DAC_PIN_BIT = 5;
	localparam int DAC_SRC_LO = 2;
	localparam logic [7:0] DAC_CTRL_MASK = 8'h00ac;
	localparam logic [7:0] DAC_CTRL_RST = 8'h0000;
	localparam logic [7:0] DAC_LEVEL_RST = 8'h0000;
	localparam int CMP_ON_BIT = 7;
	localparam int CMP_RES_BIT = 6;
	localparam int CMP_OE_BIT = 5;
	localparam int CMP_INV_BIT = 4;
	localparam int CMP_SP_BIT = 2;
	localparam int CMP_HYS_BIT = 1;
	localparam int CMP_SYNC_BIT = 0;
	localparam logic [7:0] CMP_A_MASK = 8'h00b7;
	localparam logic [7:0] CMP_A_RST = 8'h0004;
	localparam int CMP_RISE_BIT = 7;
	localparam int CMP_FALL_BIT = 6;
	localparam int CMP_PCH_LO = 4;
	localparam logic [7:0] CMP_B_MASK = 8'h00f7;
	localparam logic [7:0] CMP_B_RST = 8'h0000;
	typedef enum logic [1:0] {
		DSRC_SUPPLY = 2'b00,
		DSRC_EXT_REF = 2'b01,
		DSRC_FIXED_BUF2 = 2'b10,
		DSRC_RESERVED = 2'b11
	} cdr_dac_src_e;
	typedef enum logic [1:0] {
		PSEL_PIN = 2'b00,
		PSEL_DAC = 2'b01,
		PSEL_FIXED_BUF2 = 2'b10,
		PSEL_GROUND = 2'b11
	} cdr_pos_sel_e;
	typedef enum logic [2:0] {
		APB_IDLE = 3'b001,
		APB_SETUP = 3'b010,
		APB_ACCESS = 3'b100
	} cdr_apb_e;
endpackage

// >>> cdr_cmp_if.sv
/*
 Interface carrying one comparator's control and result signals between the
 register top and a comparator channel.
 Assumes single clock domain.
*/
`timescale 1ns/100ps
interface cdr_cmp_if;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic raw;
	logic tmr_clk;
	logic result;
	logic pin_out;
	logic edge_hit;
	modport top (output ctrl_a, output ctrl_b, output raw, output tmr_clk,
		input result, input pin_out, input edge_hit);
	modport chan (input ctrl_a, input ctrl_b, input raw, input tmr_clk,
		output result, output pin_out, output edge_hit);
endinterface

// >>> cdr_cmp_chan.sv
/*
 One comparator channel: polarity, per-cycle latch, gate-timer sync and edge
 detection.
 Assumes the raw comparison and prescaled timer clock are synchronous inputs.
*/
`timescale 1ns/100ps
module cdr_cmp_chan (
	input wire logic clk_sys,
	input wire logic sys_rst,
	cdr_cmp_if.chan cif
);
	logic pol_out;
	logic res_r, res_nxt;
	logic sync_r, sync_nxt;
	logic tclk_r, tclk_nxt;
	logic on;

	assign on = cif.ctrl_a[cdr_pkg::CMP_ON_BIT];
	// Disabled comparator reads low before inversion
	assign pol_out = (on & cif.raw) ^ cif.ctrl_a[cdr_pkg::CMP_INV_BIT]; // [R10] [R12] [R17]

	always_comb begin
		res_nxt = pol_out; // [R16]
		tclk_nxt = cif.tmr_clk;
		sync_nxt = sync_r;
		if (tclk_r && !cif.tmr_clk) begin
			sync_nxt = pol_out; // [R22]
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			res_r <= 1'b0;
			sync_r <= 1'b0;
			tclk_r <= 1'b0;
		end else begin
			res_r <= res_nxt;
			sync_r <= sync_nxt;
			tclk_r <= tclk_nxt;
		end
	end

	assign cif.result = res_r; // [R13]
	// Unregistered unless sync selected
	assign cif.pin_out = cif.ctrl_a[cdr_pkg::CMP_SYNC_BIT] ? sync_r : pol_out; // [R16] [R20]
	assign cif.edge_hit = (cif.ctrl_b[cdr_pkg::CMP_RISE_BIT] & pol_out & ~res_r)
		| (cif.ctrl_b[cdr_pkg::CMP_FALL_BIT] & ~pol_out & res_r); // [R23]
endmodule // cdr_cmp_chan

// >>> cdr_top.sv
/*
 Comparator and reference DAC control top: APB register file, DAC pin control,
 two comparator channels, port override and gate-timer outputs.
 Assumes APB master on clk_sys; analog parts sit outside and use the outputs.
*/
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
module cdr_top #(
	parameter int NUM_CMP = 2
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CMP-1:0] cmp_raw,
	input wire logic [NUM_CMP-1:0] tmr_clk_pre,
	input wire logic [NUM_CMP-1:0] pin_direction,
	input wire logic [NUM_CMP-1:0] port_latch,
	output logic [NUM_CMP-1:0] cmp_pin_drive,
	output logic [NUM_CMP-1:0] cmp_pin_oe,
	output logic [NUM_CMP-1:0] cmp_gate_out,
	output logic [NUM_CMP-1:0] cmp_enable,
	output logic [NUM_CMP-1:0] cmp_speed_sel,
	output logic [NUM_CMP-1:0] cmp_hysteresis_en,
	output logic [2*NUM_CMP-1:0] cmp_pos_input_sel,
	output logic [3*NUM_CMP-1:0] cmp_neg_input_sel,
	output logic [NUM_CMP-1:0] cmp_irq_flag,
	input wire logic dac_pin_in,
	output logic ref_dac_on,
	output logic ref_dac_pin_out_en,
	output logic [1:0] ref_dac_pos_source,
	output logic ref_dac_src_reserved,
	output logic [7:0] ref_dac_level_code,
	output logic dac_pin_digital_off,
	output logic dac_pin_read
);
	//--------------------------------------------------
	// Registers
	//--------------------------------------------------
	logic [7:0] dac_ctrl_r, dac_ctrl_nxt;
	logic [7:0] dac_lvl_r, dac_lvl_nxt;
	logic [7:0] cmp_a_r [NUM_CMP];
	logic [7:0] cmp_a_nxt [NUM_CMP];
	logic [7:0] cmp_b_r [NUM_CMP];
	logic [7:0] cmp_b_nxt [NUM_CMP];
	logic [NUM_CMP-1:0] flag_r, flag_nxt;
	logic [NUM_CMP-1:0] res_v, pin_v, hit_v;
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;
	cdr_pkg::cdr_apb_e st_r, st_nxt;
	logic wr_hit, rd_hit, mapped;
	logic [7:0] wb;

	assign wr_hit = psel && penable && pwrite && (st_r == cdr_pkg::APB_ACCESS);
	assign rd_hit = psel && !penable;
	assign wb = pwdata[7:0];

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			cdr_pkg::OFF_DAC_CTRL, cdr_pkg::OFF_DAC_LEVEL, cdr_pkg::OFF_CMP_A0,
			cdr_pkg::OFF_CMP_B0, cdr_pkg::OFF_CMP_A1, cdr_pkg::OFF_CMP_B1,
			cdr_pkg::OFF_MIRROR, cdr_pkg::OFF_IRQ_FLAG, cdr_pkg::OFF_PORT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	//--------------------------------------------------
	// APB sequencing, one wait state
	//--------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			cdr_pkg::APB_IDLE: begin
				if (psel && !penable) begin
					st_nxt = cdr_pkg::APB_SETUP;
				end
			end
			cdr_pkg::APB_SETUP: begin
				st_nxt = cdr_pkg::APB_ACCESS;
			end
			cdr_pkg::APB_ACCESS: begin
				st_nxt = (psel && !penable) ? cdr_pkg::APB_SETUP : cdr_pkg::APB_IDLE;
			end
			default: begin
				st_nxt = cdr_pkg::APB_IDLE;
			end
		endcase
	end

	assign pready = (st_r == cdr_pkg::APB_ACCESS);
	assign pslverr = (st_r == cdr_pkg::APB_ACCESS) && err_r;
	assign prdata = rdata_r;

	//--------------------------------------------------
	// Register next values
	//--------------------------------------------------
	always_comb begin
		dac_ctrl_nxt = dac_ctrl_r;
		dac_lvl_nxt = dac_lvl_r;
		flag_nxt = flag_r;
		cmp_a_nxt = cmp_a_r;
		cmp_b_nxt = cmp_b_r;
		// No sleep input: control is simply held across sleep and wake
		if (wr_hit && mapped && pstrb[0]) begin // [R25] [R05]
			case (paddr)
				cdr_pkg::OFF_DAC_CTRL: dac_ctrl_nxt = wb & cdr_pkg::DAC_CTRL_MASK; // [R09] [R01] [R02]
				cdr_pkg::OFF_DAC_LEVEL: dac_lvl_nxt = wb; // [R08]
				cdr_pkg::OFF_CMP_A0: cmp_a_nxt[0] = wb & cdr_pkg::CMP_A_MASK; // [R11]
				cdr_pkg::OFF_CMP_B0: cmp_b_nxt[0] = wb & cdr_pkg::CMP_B_MASK;
				cdr_pkg::OFF_CMP_A1: cmp_a_nxt[1] = wb & cdr_pkg::CMP_A_MASK;
				cdr_pkg::OFF_CMP_B1: cmp_b_nxt[1] = wb & cdr_pkg::CMP_B_MASK;
				// Write 1 clears flag
				cdr_pkg::OFF_IRQ_FLAG: flag_nxt = flag_r & ~wb[NUM_CMP-1:0];
				default: begin
				end
			endcase
		end
		// Set wins over a simultaneous clear
		flag_nxt = flag_nxt | hit_v; // [R23]
	end

	//--------------------------------------------------
	// Read data and error, captured in setup
	//--------------------------------------------------
	always_comb begin
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (rd_hit) begin
			err_nxt = !mapped;
			rdata_nxt = 32'h0000_0000;
			case (paddr)
				cdr_pkg::OFF_DAC_CTRL: rdata_nxt[7:0] = dac_ctrl_r; // [R09]
				cdr_pkg::OFF_DAC_LEVEL: rdata_nxt[7:0] = dac_lvl_r;
				cdr_pkg::OFF_CMP_A0: begin
					rdata_nxt[7:0] = cmp_a_r[0];
					rdata_nxt[cdr_pkg::CMP_RES_BIT] = res_v[0]; // [R13]
				end
				cdr_pkg::OFF_CMP_B0: rdata_nxt[7:0] = cmp_b_r[0];
				cdr_pkg::OFF_CMP_A1: begin
					rdata_nxt[7:0] = cmp_a_r[1];
					rdata_nxt[cdr_pkg::CMP_RES_BIT] = res_v[1];
				end
				cdr_pkg::OFF_CMP_B1: rdata_nxt[7:0] = cmp_b_r[1];
				cdr_pkg::OFF_MIRROR: rdata_nxt[NUM_CMP-1:0] = res_v; // [R13]
				cdr_pkg::OFF_IRQ_FLAG: rdata_nxt[NUM_CMP-1:0] = flag_r;
				cdr_pkg::OFF_PORT: rdata_nxt[0] = dac_pin_read; // [R04]
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= cdr_pkg::APB_IDLE;
			dac_ctrl_r <= cdr_pkg::DAC_CTRL_RST; // [R06]
			dac_lvl_r <= cdr_pkg::DAC_LEVEL_RST; // [R06]
			flag_r <= '0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
			for (int i = 0; i < NUM_CMP; i++) begin
				cmp_a_r[i] <= cdr_pkg::CMP_A_RST; // [R18]
				cmp_b_r[i] <= cdr_pkg::CMP_B_RST;
			end
		end else begin
			st_r <= st_nxt;
			dac_ctrl_r <= dac_ctrl_nxt;
			dac_lvl_r <= dac_lvl_nxt;
			flag_r <= flag_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
			cmp_a_r <= cmp_a_nxt;
			cmp_b_r <= cmp_b_nxt;
		end
	end

	//--------------------------------------------------
	// DAC outputs
	//--------------------------------------------------
	assign ref_dac_on = dac_ctrl_r[cdr_pkg::DAC_ON_BIT]; // [R01]
	assign ref_dac_pin_out_en = dac_ctrl_r[cdr_pkg::DAC_PIN_BIT]; // [R02]
	assign ref_dac_pos_source = dac_ctrl_r[cdr_pkg::DAC_SRC_LO +: 2]; // [R07]
	assign ref_dac_src_reserved = (ref_dac_pos_source == cdr_pkg::DSRC_RESERVED); // [R07]
	assign ref_dac_level_code = dac_lvl_r; // [R08]
	assign dac_pin_digital_off = ref_dac_pin_out_en; // [R03]
	assign dac_pin_read = ref_dac_pin_out_en ? 1'b0 : dac_pin_in; // [R04]

	//--------------------------------------------------
	// Comparator channels
	//--------------------------------------------------
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
		cdr_cmp_if cif ();
		assign cif.ctrl_a = cmp_a_r[g];
		assign cif.ctrl_b = cmp_b_r[g];
		assign cif.raw = cmp_raw[g];
		assign cif.tmr_clk = tmr_clk_pre[g];
		assign res_v[g] = cif.result;
		assign pin_v[g] = cif.pin_out;
		assign hit_v[g] = cif.edge_hit;
		cdr_cmp_chan u_chan (
			.clk_sys(clk_sys),
			.sys_rst(sys_rst),
			.cif(cif)
		);
		logic oe_bit;
		assign oe_bit = cmp_a_r[g][cdr_pkg::CMP_OE_BIT];
		// Override chosen by out-enable alone; result shown only when on
		assign cmp_pin_drive[g] = oe_bit
			? (pin_v[g] & cmp_a_r[g][cdr_pkg::CMP_ON_BIT]) : port_latch[g]; // [R15] [R14]
		assign cmp_pin_oe[g] = ~pin_direction[g]; // [R14]
		assign cmp_gate_out[g] = pin_v[g]; // [R20]
		assign cmp_enable[g] = cmp_a_r[g][cdr_pkg::CMP_ON_BIT]; // [R12]
		assign cmp_speed_sel[g] = cmp_a_r[g][cdr_pkg::CMP_SP_BIT]; // [R18]
		assign cmp_hysteresis_en[g] = cmp_a_r[g][cdr_pkg::CMP_HYS_BIT]; // [R19]
		assign cmp_pos_input_sel[2*g +: 2] = cmp_b_r[g][cdr_pkg::CMP_PCH_LO +: 2]; // [R24]
		assign cmp_neg_input_sel[3*g +: 3] = cmp_b_r[g][2:0];
	end

	assign cmp_irq_flag = flag_r; // [R23]
endmodule // cdr_top

// >>> cdr_properties.sv
/*
 Checker of port relations for the comparator and reference DAC block.
 Assumes it is bound into cdr_top; one clock, active-high reset.
*/
`timescale 1ns/100ps
module cdr_properties #(
	parameter int NUM_CMP = 2
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [NUM_CMP-1:0] cmp_enable,
	input wire logic ref_dac_on,
	input wire logic ref_dac_pin_out_en,
	input wire logic [1:0] ref_dac_pos_source,
	input wire logic ref_dac_src_reserved,
	input wire logic [7:0] ref_dac_level_code,
	input wire logic dac_pin_read
);
	logic wr_ctrl;
	assign wr_ctrl = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h000;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence wr_at(logic [11:0] a);
		psel && penable && pready && pwrite && pstrb[0] && paddr == a;
	endsequence
	// Access phase: one cycle without ready, then ready
	sequence access_wait;
		!pready ##1 pready;
	endsequence
	dac_enable_a: assert property (wr_at(12'h000) |=> ref_dac_on == $past(pwdata[7]))
		else $error("dac enable wrong");
	pin_route_a: assert property (wr_at(12'h000)
		|=> ref_dac_pin_out_en == $past(pwdata[5]))
		else $error("dac pin route wrong");
	pin_read_a: assert property (ref_dac_pin_out_en |-> !dac_pin_read)
		else $error("dac pin read not zero");
	ctrl_hold_a: assert property (!wr_ctrl |=> $stable({ref_dac_on, ref_dac_pin_out_en}))
		else $error("dac control changed");
	src_flag_a: assert property (ref_dac_src_reserved == (ref_dac_pos_source == 2'b11))
		else $error("reserved source flag wrong");
	level_a: assert property (wr_at(12'h004) |=> ref_dac_level_code == $past(pwdata[7:0]))
		else $error("level code wrong");
	cmp_enable_a: assert property (wr_at(12'h010) |=> cmp_enable[1] == $past(pwdata[7]))
		else $error("comparator enable wrong");
	apb_ready_a: assert property (psel && !penable |=> access_wait)
		else $error("no ready in access");
endmodule // cdr_properties
bind cdr_top cdr_properties #(.NUM_CMP(NUM_CMP)) cdr_properties_inst (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.cmp_enable(cmp_enable), .ref_dac_on(ref_dac_on), .ref_dac_pin_out_en(ref_dac_pin_out_en),
	.ref_dac_pos_source(ref_dac_pos_source), .ref_dac_src_reserved(ref_dac_src_reserved),
	.ref_dac_level_code(ref_dac_level_code), .dac_pin_read(dac_pin_read)
);

// >>> tb.sv
/*
 Self-checking bench for cdr_top: APB register tasks and port checks.
 Assumes the package, design and bound checker are compiled first.
*/
`timescale 1ns/100ps
module tb;
	logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic dac_pin_in = 1'b1, pready, pslverr, e, ref_dac_on, ref_dac_pin_out_en;
	logic ref_dac_src_reserved, dac_pin_digital_off, dac_pin_read;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [3:0] pstrb = 4'hf, wstrb = 4'hf, cmp_pos_input_sel;
	logic [1:0] cmp_raw = 2'b00, tmr_clk_pre = 2'b00, pin_direction = 2'b00, port_latch = 2'b00;
	logic [1:0] cmp_pin_drive, cmp_pin_oe, cmp_gate_out, cmp_enable, cmp_speed_sel;
	logic [1:0] cmp_hysteresis_en, cmp_irq_flag, ref_dac_pos_source, res = 2'b00;
	logic [5:0] cmp_neg_input_sel;
	logic [7:0] ref_dac_level_code;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	cdr_top cdr_top_inst (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
		.tmr_clk_pre(tmr_clk_pre), .pin_direction(pin_direction), .port_latch(port_latch),
		.cmp_pin_drive(cmp_pin_drive), .cmp_pin_oe(cmp_pin_oe), .cmp_gate_out(cmp_gate_out),
		.cmp_enable(cmp_enable), .cmp_speed_sel(cmp_speed_sel),
		.cmp_hysteresis_en(cmp_hysteresis_en), .cmp_pos_input_sel(cmp_pos_input_sel),
		.cmp_neg_input_sel(cmp_neg_input_sel), .cmp_irq_flag(cmp_irq_flag),
		.dac_pin_in(dac_pin_in), .ref_dac_on(ref_dac_on), .ref_dac_pin_out_en(ref_dac_pin_out_en),
		.ref_dac_pos_source(ref_dac_pos_source), .ref_dac_src_reserved(ref_dac_src_reserved),
		.ref_dac_level_code(ref_dac_level_code), .dac_pin_digital_off(dac_pin_digital_off),
		.dac_pin_read(dac_pin_read)
	);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	// ----
	// Bus cycle: setup, access until ready, release
	// ----
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= wstrb;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Ready is judged at the edge; only the bench timeout ends a wait
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), q, x);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wr(12'h000, 8'hff);
		rd(12'h000, 8'hac);
		rd(12'h020, 8'h00);
		chk("dig_off", dac_pin_digital_off, 1);
		chk("dac_on", ref_dac_on, 1);
		for (int s = 0; s < 4; s++) begin
			wr(12'h000, 8'h80 | (s << 2));
			wt(1);
			chk("src", ref_dac_pos_source, s);
			chk("rsv", ref_dac_src_reserved, s == 3);
		end
		chk("pin_off", ref_dac_pin_out_en, 0);
		rd(12'h020, 8'h01);
		wr(12'h004, 8'ha5);
		wstrb <= 4'h0;
		wr(12'h004, 8'h5a);
		wstrb <= 4'hf;
		rd(12'h004, 8'ha5);
		apb(1'b0, 12'h040, 32'h0000_0000);
		chk("slverr", e, 1);
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 4; i++) begin
				@(posedge clk_sys);
				cmp_raw[c] <= i[0];
				wr(12'h008 + 12'(8 * c), 8'ha2 | ((i & 2) << 3));
				res[c] = i[0] ^ i[1];
				rd(12'h008 + 12'(8 * c), 8'ha2 | ((i & 2) << 3) | (res[c] ? 8'h40 : 8'h00));
				rd(12'h018, {30'h0, res});
				wt(1);
				chk("gate", cmp_gate_out[c], res[c]);
				chk("pin", cmp_pin_drive[c], res[c]);
			end
		end
		chk("hys_sp", {cmp_hysteresis_en, cmp_speed_sel}, 4'b1100);
		chk("cmp_en", cmp_enable, 2'b11);
		@(posedge clk_sys);
		pin_direction <= 2'b01;
		wt(1);
		chk("pin_oe", cmp_pin_oe, 2'b10);
		wr(12'h00c, 8'hbd);
		rd(12'h00c, 8'hb5);
		chk("pos_sel", cmp_pos_input_sel[1:0], 2'b11);
		wr(12'h01c, 8'h03);
		@(posedge clk_sys);
		cmp_raw[0] <= 1'b0;
		rd(12'h01c, 8'h01);
		chk("irq_port", cmp_irq_flag, 2'b01);
		wr(12'h01c, 8'h01);
		@(posedge clk_sys);
		cmp_raw[0] <= 1'b1;
		rd(12'h01c, 8'h00);
		@(posedge clk_sys);
		tmr_clk_pre[1] <= 1'b1;
		wr(12'h010, 8'h81);
		wt(2);
		chk("sync_hold", cmp_gate_out[1], 0);
		@(posedge clk_sys);
		tmr_clk_pre[1] <= 1'b0;
		wt(3);
		chk("sync_fall", cmp_gate_out[1], 1);
		wr(12'h000, 8'ha0);
		wt(1);
		chk("pin_on", ref_dac_pin_out_en, 1);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		wt(2);
		chk("rst", {ref_dac_on, ref_dac_pin_out_en, ref_dac_level_code}, 10'h000);
		chk("rst_cmp", cmp_enable, 2'b00);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(12'h010, 8'h04);
		final_report();
	end
endmodule // tb
